// >>> design/tpd_port.sv
// Test-access port controller and processor debug-halt handshake
`include "tpd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tpd_port (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo_o,
   output logic tdo_oe,
   input wire logic tap_reset_n,
   input wire logic system_power_good,
   input wire logic tap_power_good,
   input wire logic manufacturing_gear_select,
   input wire logic halt_request_n,
   output logic halt_ready_o,
   output logic halt_ready_oe,
   input wire logic cpu_halted,
   output logic cpu_halt_req
);
   // Gear select has no function here; board keeps it low
   logic unused_gear;
   assign unused_gear = manufacturing_gear_select;

   // Port reset combines all three enabling conditions
   logic tap_rst_n;
   assign tap_rst_n = tap_reset_n & system_power_good & tap_power_good;

   tpd_pkg::tpd_state_t st_r, st_nxt;
   logic [`TPD_IR_W-1:0] ir_sh_r, ir_r;
   logic [`TPD_ID_W-1:0] dr_sh_r;
   logic halt_bit_r;
   logic tdo_r, tdo_en_r;

   // Standard controller walk on mode select
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         tpd_pkg::TLR: st_nxt = tms ? tpd_pkg::TLR : tpd_pkg::RTI;
         tpd_pkg::RTI: st_nxt = tms ? tpd_pkg::SEL_DR : tpd_pkg::RTI;
         tpd_pkg::SEL_DR: st_nxt = tms ? tpd_pkg::SEL_IR : tpd_pkg::CAP_DR;
         tpd_pkg::CAP_DR: st_nxt = tms ? tpd_pkg::EX1_DR : tpd_pkg::SH_DR;
         tpd_pkg::SH_DR: st_nxt = tms ? tpd_pkg::EX1_DR : tpd_pkg::SH_DR;
         tpd_pkg::EX1_DR: st_nxt = tms ? tpd_pkg::UPD_DR : tpd_pkg::PA_DR;
         tpd_pkg::PA_DR: st_nxt = tms ? tpd_pkg::EX2_DR : tpd_pkg::PA_DR;
         tpd_pkg::EX2_DR: st_nxt = tms ? tpd_pkg::UPD_DR : tpd_pkg::SH_DR;
         tpd_pkg::UPD_DR: st_nxt = tms ? tpd_pkg::SEL_DR : tpd_pkg::RTI;
         tpd_pkg::SEL_IR: st_nxt = tms ? tpd_pkg::TLR : tpd_pkg::CAP_IR;
         tpd_pkg::CAP_IR: st_nxt = tms ? tpd_pkg::EX1_IR : tpd_pkg::SH_IR;
         tpd_pkg::SH_IR: st_nxt = tms ? tpd_pkg::EX1_IR : tpd_pkg::SH_IR;
         tpd_pkg::EX1_IR: st_nxt = tms ? tpd_pkg::UPD_IR : tpd_pkg::PA_IR;
         tpd_pkg::PA_IR: st_nxt = tms ? tpd_pkg::EX2_IR : tpd_pkg::PA_IR;
         tpd_pkg::EX2_IR: st_nxt = tms ? tpd_pkg::UPD_IR : tpd_pkg::SH_IR;
         tpd_pkg::UPD_IR: st_nxt = tms ? tpd_pkg::SEL_DR : tpd_pkg::RTI;
         default: st_nxt = tpd_pkg::TLR;
      endcase
   end

   // Controller, registers and output below run on the test clock; halt handshake on core clock
   always_ff @(posedge tck or negedge tap_rst_n) begin
      if (!tap_rst_n) st_r <= tpd_pkg::TLR;
      else st_r <= st_nxt;
   end

   always_ff @(posedge tck or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         ir_sh_r <= `TPD_IR_RST;
         ir_r <= `TPD_IR_RST;
      end else if (st_r == tpd_pkg::TLR) begin
         ir_r <= `TPD_IR_RST;
      end else if (st_r == tpd_pkg::CAP_IR) begin
         ir_sh_r <= `TPD_IR_CAP;
      end else if (st_r == tpd_pkg::SH_IR) begin
         ir_sh_r <= {tdi, ir_sh_r[`TPD_IR_W-1:1]};
      end else if (st_r == tpd_pkg::UPD_IR) begin
         ir_r <= ir_sh_r;
      end
   end

   // Data path: identity, one-bit halt control, else bypass
   always_ff @(posedge tck or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         dr_sh_r <= '0;
         halt_bit_r <= 1'b0;
      end else if (st_r == tpd_pkg::CAP_DR) begin
         if (ir_r == `TPD_IR_IDCODE) dr_sh_r <= `TPD_ID_VAL;
         else if (ir_r == `TPD_IR_HALT)
            dr_sh_r <= {{(`TPD_ID_W-1){1'b0}}, halt_bit_r};
         else dr_sh_r <= '0;
      end else if (st_r == tpd_pkg::SH_DR) begin
         if (ir_r == `TPD_IR_IDCODE)
            dr_sh_r <= {tdi, dr_sh_r[`TPD_ID_W-1:1]};
         else
            dr_sh_r <= {{(`TPD_ID_W-1){1'b0}}, tdi};
      end else if (st_r == tpd_pkg::UPD_DR && ir_r == `TPD_IR_HALT) begin
         halt_bit_r <= dr_sh_r[0];
      end
   end

   // Output changes on falling edge; released outside shift
   always_ff @(negedge tck or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         tdo_r <= 1'b1;
         tdo_en_r <= 1'b0;
      end else begin
         tdo_en_r <= (st_r == tpd_pkg::SH_DR) || (st_r == tpd_pkg::SH_IR);
         tdo_r <= (st_r == tpd_pkg::SH_IR) ? ir_sh_r[0] : dr_sh_r[0];
      end
   end

   // Open drain: drive only a low level
   assign tdo_o = 1'b0;
   assign tdo_oe = tdo_en_r & ~tdo_r;

   // Halt handshake on core clock; pins pass two flops first
   logic [`TPD_HALT_W-1:0] req_sync_r, tap_sync_r, done_sync_r, pg_sync_r;
   logic halt_req_r, ready_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         req_sync_r <= '0;
         tap_sync_r <= '0;
         done_sync_r <= '0;
         pg_sync_r <= '0;
      end else begin
         req_sync_r <= {req_sync_r[0], ~halt_request_n};
         tap_sync_r <= {tap_sync_r[0], halt_bit_r};
         done_sync_r <= {done_sync_r[0], cpu_halted};
         pg_sync_r <= {pg_sync_r[0], system_power_good};
      end
   end

   // Request from pin or through the port, only once powered
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) halt_req_r <= 1'b0;
      else halt_req_r <= pg_sync_r[1] &
                         (req_sync_r[1] | tap_sync_r[1]);
   end

   // Ready only while halted in answer to a request
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) ready_r <= 1'b0;
      else ready_r <= halt_req_r & done_sync_r[1];
   end

   assign cpu_halt_req = halt_req_r;
   assign halt_ready_o = 1'b0;
   assign halt_ready_oe = ready_r;
endmodule : tpd_port
`default_nettype wire

// >>> design/tpd_defines.svh
// Constants for the test-access and debug-halt port
`ifndef TPD_DEFINES_SVH
`define TPD_DEFINES_SVH
`define TPD_IR_W 4
`define TPD_IR_RST 4'h1
`define TPD_IR_IDCODE 4'h1
`define TPD_IR_BYPASS 4'hF
`define TPD_IR_HALT 4'h8
`define TPD_IR_CAP 4'h1
`define TPD_ID_W 32
`define TPD_ID_VAL 32'h1234ABCD
`define TPD_HALT_W 2
`endif

// >>> design/tpd_pkg.sv
// Types for the test-access and debug-halt port
package tpd_pkg;
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tpd_state_t;
endpackage : tpd_pkg

// >>> tb/tpd_port_monitor.sv
// Port checker for the test-access and debug-halt block
`timescale 1ns/1ps
`default_nettype none
module tpd_port_monitor (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic tdo_oe,
   input wire logic tap_reset_n,
   input wire logic system_power_good,
   input wire logic tap_power_good,
   input wire logic halt_request_n,
   input wire logic halt_ready_oe,
   input wire logic cpu_halted,
   input wire logic cpu_halt_req
);
   // Tap outputs move at half the core_clk rate, so it samples them too
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_pg; !system_power_good |-> !tdo_oe; endproperty
   a_pg: assert property (p_pg) else $error("tdo driven, power low");
   property p_tpg; !tap_power_good |-> !tdo_oe; endproperty
   a_tpg: assert property (p_tpg) else $error("tdo driven, tap off");
   property p_trst; !tap_reset_n |-> !tdo_oe; endproperty
   a_trst: assert property (p_trst) else $error("tdo in reset");
   property p_req; $fell(halt_request_n) |-> ##[1:4] cpu_halt_req; endproperty
   a_req: assert property (p_req) else $error("halt not asked");
   property p_rel; $rose(halt_request_n) |-> ##[1:5] !cpu_halt_req; endproperty
   a_rel: assert property (p_rel) else $error("halt not dropped");
   property p_rdy; cpu_halt_req && $rose(cpu_halted) |-> ##[1:4] halt_ready_oe;
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready late");
   property p_rdyr; $rose(halt_ready_oe) |-> cpu_halted && cpu_halt_req;
   endproperty
   a_rdyr: assert property (p_rdyr) else $error("ready unasked");
   property p_rdyf; $fell(cpu_halt_req) |-> ##[0:2] !halt_ready_oe; endproperty
   a_rdyf: assert property (p_rdyf) else $error("ready stuck");
endmodule : tpd_port_monitor
`default_nettype wire

// >>> tb/tpd_host.sv
// Debug host model: test clock, mode select and serial data
`timescale 1ns/1ps
`default_nettype none
module tpd_host (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo_line
);
   logic [31:0] got;
   // Snapshot taken right after the shift bits, before the exit ticks
   logic [31:0] last;
   // Clock rests low between frames; the port must not need it running
   initial {tck, tms, tdi} = 3'h2;
   task automatic tick(input logic m, input logic d);
      {tms, tdi} = {m, d};
      #40 tck = 1'h1;
      got = {tdo_line, got[31:1]};
      #40 tck = 1'h0;
   endtask : tick
   task automatic scan(input logic ir, input logic [31:0] v, input int n);
      for (int i = 0; i < 4 + ir; i++) tick(i == 1 || (ir && i == 2), 1'h0);
      for (int i = 0; i < n; i++) tick(i == n - 1, v[i]);
      last = got;
      tick(1'h1, 1'h0);
      tick(1'h0, 1'h0);
   endtask : scan
endmodule : tpd_host
`default_nettype wire

// >>> tb/tpd_port_tb.sv
// Bench for the test-access and debug-halt block
`timescale 1ns/1ps
`default_nettype none
`include "tpd_defines.svh"
module tpd_port_tb;
   logic core_clk = 1'h0, rstn, tck, tms, tdi, tdo_o, tdo_oe, tap_reset_n;
   logic system_power_good, tap_power_good, manufacturing_gear_select;
   logic halt_request_n, halt_ready_o, halt_ready_oe, cpu_halted;
   logic cpu_halt_req;
   logic [2:0] gates;
   wire logic tdo_line = tdo_oe ? tdo_o : 1'h1; // Pull-up when released
   int mismatches = 0, checks_done = 0;
   assign {tap_reset_n, system_power_good, tap_power_good} = gates;
   tpd_port uut (.*);
   tpd_host h (.*);
   initial forever #20 core_clk = ~core_clk;
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) mismatches++;
      if (s !== e) $display("BAD %0t seen %h exp %h", $time, s, e);
   endtask : chk
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   task t_tap;
      for (int i = 0; i < 4; i++) begin
         @(negedge core_clk) gates = 3'h7 ^ (3'h1 << i);
         h.scan(1'h0, 32'h0, 32);
         chk(h.last, i < 3 ? 32'hFFFFFFFF : `TPD_ID_VAL);
      end
      h.scan(1'h1, 32'hF, 4);
      chk(h.last[31:28], `TPD_IR_CAP);
      h.scan(1'h0, 32'h1, 2);
      chk(h.last[31:30], 2'h2);
      chk(tdo_o, 1'h0);
      $display("tap test done");
   endtask : t_tap
   task t_halt;
      @(negedge core_clk) halt_request_n = 1'h0;
      repeat (4) @(negedge core_clk);
      chk(cpu_halt_req, 1'h1);
      cpu_halted = 1'h1;
      repeat (4) @(negedge core_clk);
      chk(halt_ready_oe, 1'h1);
      halt_request_n = 1'h1;
      repeat (5) @(negedge core_clk);
      chk({cpu_halt_req, halt_ready_oe, halt_ready_o}, 3'h0);
      $display("halt test done");
   endtask : t_halt
   initial begin
      {rstn, gates, manufacturing_gear_select} = 5'h0;
      {halt_request_n, cpu_halted} = 2'h2;
      repeat (4) @(negedge core_clk);
      rstn = 1'h1;
      t_tap;
      t_halt;
      final_report;
   end
endmodule : tpd_port_tb
bind tpd_port tpd_port_monitor mon (.*);
`default_nettype wire
